/* File: dosc_pkg.sv */
package dosc_pkg;

    // Direction setting codes.
    localparam logic DIR_CCW_FWD = 1'h0;
    localparam logic DIR_CW_FWD = 1'h1;

    // Limit enable field positions inside the limit enable setting.
    localparam int LIM_FWD_DIS_BIT = 1;
    localparam int LIM_REV_DIS_BIT = 2;
    localparam int LIM_SET_W = 4;
    localparam logic [3:0] LIM_SET_RESET = 4'h0;

    // Stop method codes.
    localparam logic [2:0] STOP_DB_COAST = 3'h0;
    localparam logic [2:0] STOP_COAST = 3'h1;
    localparam logic [2:0] STOP_PLUG_DB_COAST = 3'h2;
    localparam logic [2:0] STOP_PLUG_CO_COAST = 3'h3;
    localparam logic [2:0] STOP_PLUG_DB_CLAMP = 3'h4;
    localparam logic [2:0] STOP_PLUG_CO_CLAMP = 3'h5;
    localparam logic [2:0] STOP_SET_RESET = 3'h0;

    // Plug braking torque in percent of rated torque.
    localparam logic [8:0] PLUG_TORQUE_MAX = 9'h12C;
    localparam logic [8:0] PLUG_TORQUE_RESET = 9'h12C;

    // Limit switch debounce time.
    localparam int CLK_MHZ = 50;
    localparam int DEBOUNCE_US = 2000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

    // Stop action driven to the power stage.
    typedef enum logic [4:0] {
        ACT_RUN = 5'h01,
        ACT_DB = 5'h02,
        ACT_COAST = 5'h04,
        ACT_PLUG = 5'h08,
        ACT_CLAMP = 5'h10
    } dosc_act_t;

    // Overtravel status travelling together.
    typedef struct packed {
        logic fwdOvertravel;
        logic revOvertravel;
        logic fwdBlocked;
        logic revBlocked;
    } dosc_ot_t;

endpackage : dosc_pkg

/* File: dosc_debounce.sv */
`timescale 1ns/10ps
`default_nettype none
module dosc_debounce #(
    parameter int COUNT = 100000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rawIn,
    output logic cleanOut
);
    logic sync1_ff;
    logic sync2_ff;
    logic [31:0] cnt_ff;
    logic clean_ff;

    // Two-stage synchroniser; only the second stage is looked at.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_ff <= 1'h0;
            sync2_ff <= 1'h0;
        end else begin
            sync1_ff <= rawIn;
            sync2_ff <= sync1_ff;
        end
    end

    // The output follows only after the input has been steady for COUNT cycles.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_ff <= 32'h0;
            clean_ff <= 1'h0;
        end else if (sync2_ff == clean_ff) begin
            cnt_ff <= 32'h0;
        end else if (cnt_ff >= 32'(COUNT - 1)) begin
            cnt_ff <= 32'h0;
            clean_ff <= sync2_ff;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    assign cleanOut = clean_ff;
endmodule : dosc_debounce
`default_nettype wire

/* File: dosc_echo.sv */
`timescale 1ns/10ps
`default_nettype none
module dosc_echo (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stepPulse,
    input wire logic stepFwd,
    output logic phaseA,
    output logic phaseB
);
    logic [1:0] phase_ff;

    // Gray sequence AB 00,01,11,10 puts B ahead for forward and A ahead for reverse.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_ff <= 2'h0;
        end else if (stepPulse) begin
            phase_ff <= stepFwd ? phase_ff + 2'h1 : phase_ff - 2'h1;
        end
    end

    assign phaseB = phase_ff[1] ^ phase_ff[0];
    assign phaseA = phase_ff[1];
endmodule : dosc_echo
`default_nettype wire

/* File: direction_overtravel_stop_control.sv */
// How it works
// - Direction setting 0 makes CCW forward, 1 makes CW forward.
// - Direction setting never changes echo or monitor output polarity.
// - Echo shows B leading for forward reference, A leading for reverse.
// - Limit input roles stay with the reference sense; the direction setting does not swap them.
// - High forward limit blocks forward motion and flags forward overtravel.
// - High reverse limit blocks reverse motion and flags reverse overtravel.
// - Motion opposite to a tripped limit stays allowed only in zero clamp.
// - Position error survives an overtravel stop until the clear input.
// - Limit enable bit 1 set ignores the forward limit input.
// - Limit enable bit 2 set ignores the reverse limit input.
// - Limit enables and stop method are latched only at power-up.
// - Method 0 brakes dynamically then coasts.
// - Method 1 coasts like servo-off then stays unpowered.
// - Methods 2,3 plug brake on overtravel then coast; servo-off DB or coast.
// - Methods 4,5 plug brake on overtravel then clamp; servo-off DB or coast.
// - Zero clamp holds a position loop around reference zero.
// - Plug torque limit 0 to 300 percent, immediate, default 300.
// - Delivered plug torque is capped at the motor rating.
`timescale 1ns/10ps
`default_nettype none
module direction_overtravel_stop_control #(
    parameter int DEBOUNCE_COUNT = dosc_pkg::DEBOUNCE_CYCLES,
    parameter int POS_W = 32,
    parameter logic [8:0] MOTOR_MAX_TORQUE = 9'h12C
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic forwardLimitInput,
    input wire logic reverseLimitInput,
    input wire logic servoOnInput_n,
    input wire logic positionErrorClearInput,
    input wire logic directionSelectSetting,
    input wire logic [3:0] limitEnableSetting,
    input wire logic [2:0] stopMethodSetting,
    input wire logic [8:0] plugBrakeTorqueLimit,
    input wire logic refPulse,
    input wire logic refFwd,
    input wire logic fbPulse,
    input wire logic fbFwd,
    input wire logic motorStopped,
    output logic shaftCcw,
    output logic motorStep,
    output logic encoderEchoPhaseA,
    output logic encoderEchoPhaseB,
    output dosc_pkg::dosc_ot_t overtravelStatus,
    output dosc_pkg::dosc_act_t stopAction,
    output logic zeroClampActive,
    output logic [8:0] plugTorqueOut,
    output logic signed [POS_W-1:0] positionError
);
    logic cfgLatched_ff;
    logic dirCfg_ff;
    logic [3:0] limCfg_ff;
    logic [2:0] stopCfg_ff;
    logic fwdClean;
    logic revClean;
    logic fwdRaw;
    logic revRaw;
    logic fwdBlock;
    logic revBlock;
    logic stepGo;
    logic echoA;
    logic echoB;
    logic servoOff;
    logic anyOt;
    logic shaftCcw_ff;
    logic motorStep_ff;
    logic echoA_ff;
    logic echoB_ff;
    dosc_pkg::dosc_ot_t ot_ff;
    dosc_pkg::dosc_act_t act_ff;
    dosc_pkg::dosc_act_t nxt_act;
    logic [8:0] torque_ff;
    logic signed [POS_W-1:0] err_ff;
    logic clamp_ff;

    // Settings are captured once on the first clock after reset release.
    // Power-up latch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfgLatched_ff <= 1'h0;
            dirCfg_ff <= dosc_pkg::DIR_CCW_FWD;
            limCfg_ff <= dosc_pkg::LIM_SET_RESET;
            stopCfg_ff <= dosc_pkg::STOP_SET_RESET;
        end else if (!cfgLatched_ff) begin
            cfgLatched_ff <= 1'h1;
            dirCfg_ff <= directionSelectSetting;
            limCfg_ff <= limitEnableSetting;
            stopCfg_ff <= stopMethodSetting;
        end
    end

    dosc_debounce #(.COUNT(DEBOUNCE_COUNT)) u_fwdDeb (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn(forwardLimitInput),
        .cleanOut(fwdClean)
    );

    dosc_debounce #(.COUNT(DEBOUNCE_COUNT)) u_revDeb (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn(reverseLimitInput),
        .cleanOut(revClean)
    );

    // Disabled limits read as permissive. Limits act in reference terms, so
    // swapping direction moves which shaft sense each limit guards.
    // Forward and reverse limit disable
    assign fwdRaw = fwdClean & ~limCfg_ff[dosc_pkg::LIM_FWD_DIS_BIT];
    assign revRaw = revClean & ~limCfg_ff[dosc_pkg::LIM_REV_DIS_BIT];
    assign fwdBlock = fwdRaw;
    assign revBlock = revRaw;

    assign servoOff = servoOnInput_n;
    assign anyOt = fwdBlock | revBlock;

    // Steps are taken while running and in zero clamp, so a move away from a
    // tripped limit stays possible; braking and coasting phases refuse them.
    function automatic logic acceptsSteps(input dosc_pkg::dosc_act_t act);
        return (act == dosc_pkg::ACT_RUN) || (act == dosc_pkg::ACT_CLAMP);
    endfunction : acceptsSteps

    // A reference step passes with servo on, in run or zero clamp, unless it heads into a tripped limit.
    // Opposite motion allowed
    assign stepGo = refPulse & ~servoOff & (refFwd ? ~fwdBlock : ~revBlock)
        & acceptsSteps(act_ff);

    // Shaft sense is the only thing the direction setting changes.
    // Direction mapping
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shaftCcw_ff <= 1'h0;
            motorStep_ff <= 1'h0;
        end else begin
            motorStep_ff <= stepGo;
            if (stepGo) begin
                shaftCcw_ff <= refFwd ^ (dirCfg_ff == dosc_pkg::DIR_CW_FWD);
            end
        end
    end

    // Echo is driven from the reference sense, never from the shaft sense.
    // Fixed output polarity
    dosc_echo u_echo (
        .clk(clk),
        .reset_n(reset_n),
        .stepPulse(stepGo),
        .stepFwd(refFwd),
        .phaseA(echoA),
        .phaseB(echoB)
    );

    // Registered echo and overtravel status.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            echoA_ff <= 1'h0;
            echoB_ff <= 1'h0;
            ot_ff <= '0;
        end else begin
            echoA_ff <= echoA;
            echoB_ff <= echoB;
            ot_ff.fwdOvertravel <= fwdBlock;
            ot_ff.revOvertravel <= revBlock;
            ot_ff.fwdBlocked <= fwdBlock | servoOff;
            ot_ff.revBlocked <= revBlock | servoOff;
        end
    end

    // Stop sequencer. Overtravel takes priority over servo-off since it is
    // the safety event; servo-on toggling is left to the host to avoid.
    // Host uses references
    always_comb begin
        nxt_act = act_ff;
        case (act_ff)
            dosc_pkg::ACT_RUN: begin
                if (anyOt) begin
                    if (stopCfg_ff == dosc_pkg::STOP_DB_COAST) begin
                        nxt_act = dosc_pkg::ACT_DB;
                    end else if (stopCfg_ff == dosc_pkg::STOP_COAST) begin
                        nxt_act = dosc_pkg::ACT_COAST;
                    end else begin
                        nxt_act = dosc_pkg::ACT_PLUG;
                    end
                end else if (servoOff) begin
                    if (stopCfg_ff == dosc_pkg::STOP_DB_COAST ||
                        stopCfg_ff == dosc_pkg::STOP_PLUG_DB_COAST ||
                        stopCfg_ff == dosc_pkg::STOP_PLUG_DB_CLAMP) begin
                        nxt_act = dosc_pkg::ACT_DB;
                    end else begin
                        nxt_act = dosc_pkg::ACT_COAST;
                    end
                end
            end
            dosc_pkg::ACT_DB: begin
                if (motorStopped) begin
                    nxt_act = dosc_pkg::ACT_COAST;
                end
            end
            dosc_pkg::ACT_PLUG: begin
                if (motorStopped) begin
                    if (stopCfg_ff == dosc_pkg::STOP_PLUG_DB_CLAMP ||
                        stopCfg_ff == dosc_pkg::STOP_PLUG_CO_CLAMP) begin
                        nxt_act = dosc_pkg::ACT_CLAMP;
                    end else begin
                        nxt_act = dosc_pkg::ACT_COAST;
                    end
                end
            end
            dosc_pkg::ACT_COAST,
            dosc_pkg::ACT_CLAMP: begin
                if (!anyOt && !servoOff) begin
                    nxt_act = dosc_pkg::ACT_RUN;
                end else if (servoOff && act_ff == dosc_pkg::ACT_CLAMP) begin
                    nxt_act = dosc_pkg::ACT_COAST;
                end
            end
            default: begin
                nxt_act = dosc_pkg::ACT_COAST;
            end
        endcase
    end

    // Power is off out of reset, so the sequencer starts in coast.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            act_ff <= dosc_pkg::ACT_COAST;
        end else begin
            act_ff <= nxt_act;
        end
    end

    // The clamp flag is registered beside the stop action, so the output
    // comes from a flip-flop instead of from a decode of the state.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clamp_ff <= 1'h0;
        end else begin
            clamp_ff <= (nxt_act == dosc_pkg::ACT_CLAMP);
        end
    end

    // Torque limit follows the input at once, clipped to range and rating.
    // Immediate torque limit
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            torque_ff <= dosc_pkg::PLUG_TORQUE_RESET;
        end else if (plugBrakeTorqueLimit > dosc_pkg::PLUG_TORQUE_MAX) begin
            torque_ff <= (MOTOR_MAX_TORQUE < dosc_pkg::PLUG_TORQUE_MAX) ?
                MOTOR_MAX_TORQUE : dosc_pkg::PLUG_TORQUE_MAX;
        end else if (plugBrakeTorqueLimit > MOTOR_MAX_TORQUE) begin
            torque_ff <= MOTOR_MAX_TORQUE;
        end else begin
            torque_ff <= plugBrakeTorqueLimit;
        end
    end

    // Position error counts accepted reference minus feedback, in reference
    // sense. It is kept through an overtravel stop; only clear or reset discards it.
    // In zero clamp accepted reference steps still count alongside the feedback.
    // Error retained
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            err_ff <= '0;
        end else if (positionErrorClearInput) begin
            err_ff <= '0;
        end else begin
            err_ff <= err_ff + POS_W'(stepGo ? (refFwd ? 1 : -1) : 0)
                - POS_W'(fbPulse ? (fbFwd ? 1 : -1) : 0);
        end
    end

    assign shaftCcw = shaftCcw_ff;
    assign motorStep = motorStep_ff;
    assign encoderEchoPhaseA = echoA_ff;
    assign encoderEchoPhaseB = echoB_ff;
    assign overtravelStatus = ot_ff;
    assign stopAction = act_ff;
    assign zeroClampActive = clamp_ff;
    assign plugTorqueOut = torque_ff;
    assign positionError = err_ff;
endmodule : direction_overtravel_stop_control
`default_nettype wire

/* File: dosc_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module dosc_assertions #(
    parameter int DEBOUNCE_COUNT = 4,
    parameter int POS_W = 32,
    parameter logic [8:0] MOTOR_MAX_TORQUE = 9'h12C
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic forwardLimitInput,
    input wire logic servoOnInput_n,
    input wire logic positionErrorClearInput,
    input wire logic directionSelectSetting,
    input wire logic [3:0] limitEnableSetting,
    input wire logic [2:0] stopMethodSetting,
    input wire logic [8:0] plugBrakeTorqueLimit,
    input wire logic refPulse,
    input wire logic refFwd,
    input wire logic motorStopped,
    input wire logic shaftCcw,
    input wire logic motorStep,
    input wire dosc_pkg::dosc_ot_t overtravelStatus,
    input wire dosc_pkg::dosc_act_t stopAction,
    input wire logic [8:0] plugTorqueOut,
    input wire logic signed [POS_W-1:0] positionError
);
    logic armed_ff;
    logic dir_ff;
    logic [3:0] lim_ff;
    logic [2:0] meth_ff;
    int high_ff;

    // Settings are taken once after reset, just as the block takes them at power-up.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            armed_ff <= 1'b1;
        end else if (armed_ff) begin
            armed_ff <= 1'b0;
            dir_ff <= directionSelectSetting;
            lim_ff <= limitEnableSetting;
            meth_ff <= stopMethodSetting;
        end
    end

    // Counts how long the forward limit line has stayed high, saturating.
    always_ff @(posedge clk) begin
        if (!reset_n || !forwardLimitInput) begin
            high_ff <= 0;
        end else if (high_ff < 1000) begin
            high_ff <= high_ff + 1;
        end
    end

    function automatic logic [8:0] capT(input logic [8:0] v);
        logic [8:0] c;
        c = (v > dosc_pkg::PLUG_TORQUE_MAX) ? dosc_pkg::PLUG_TORQUE_MAX : v;
        return (c > MOTOR_MAX_TORQUE) ? MOTOR_MAX_TORQUE : c;
    endfunction : capT

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_torqueCap;
        1 |=> plugTorqueOut == capT($past(plugBrakeTorqueLimit));
    endproperty
    a_torqueCap: assert property (p_torqueCap) else $error("plug torque wrong");
    property p_fwdRefuse;
        refPulse && refFwd && overtravelStatus.fwdBlocked ##1 overtravelStatus.fwdBlocked
        |-> !motorStep;
    endproperty
    a_fwdRefuse: assert property (p_fwdRefuse) else $error("blocked step taken");
    property p_opposite;
        refPulse && !servoOnInput_n && stopAction == dosc_pkg::ACT_CLAMP
        && (refFwd ? overtravelStatus.revOvertravel && !overtravelStatus.fwdBlocked
        : overtravelStatus.fwdOvertravel && !overtravelStatus.revBlocked) |=> motorStep;
    endproperty
    a_opposite: assert property (p_opposite) else $error("opposite step lost");
    property p_shaft;
        motorStep |-> shaftCcw == ($past(refFwd) ^ dir_ff);
    endproperty
    a_shaft: assert property (p_shaft) else $error("shaft sense wrong");
    property p_fwdDis;
        !armed_ff && lim_ff[dosc_pkg::LIM_FWD_DIS_BIT]
        |-> !overtravelStatus.fwdOvertravel && !overtravelStatus.fwdBlocked;
    endproperty
    a_fwdDis: assert property (p_fwdDis) else $error("disabled limit acted");
    property p_debounce;
        $rose(overtravelStatus.fwdOvertravel) |-> high_ff >= DEBOUNCE_COUNT;
    endproperty
    a_debounce: assert property (p_debounce) else $error("limit not debounced");
    property p_otStop;
        stopAction == dosc_pkg::ACT_RUN ##1 (overtravelStatus.fwdOvertravel
        || overtravelStatus.revOvertravel) |-> stopAction == (meth_ff == 3'h0 ?
        dosc_pkg::ACT_DB : meth_ff == 3'h1 ? dosc_pkg::ACT_COAST : dosc_pkg::ACT_PLUG);
    endproperty
    a_otStop: assert property (p_otStop) else $error("overtravel stop wrong");
    property p_offStop;
        stopAction == dosc_pkg::ACT_RUN && servoOnInput_n && !overtravelStatus.fwdOvertravel
        && !overtravelStatus.revOvertravel
        |=> stopAction == (meth_ff[0] ? dosc_pkg::ACT_COAST : dosc_pkg::ACT_DB);
    endproperty
    a_offStop: assert property (p_offStop) else $error("servo-off stop wrong");
    property p_afterStop;
        stopAction == dosc_pkg::ACT_PLUG && motorStopped
        |=> stopAction == (meth_ff[2] ? dosc_pkg::ACT_CLAMP : dosc_pkg::ACT_COAST);
    endproperty
    a_afterStop: assert property (p_afterStop) else $error("after-stop wrong");
    property p_clear;
        positionErrorClearInput |=> positionError == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("error not cleared");
endmodule : dosc_assertions

bind direction_overtravel_stop_control dosc_assertions #(
    .DEBOUNCE_COUNT(DEBOUNCE_COUNT),
    .POS_W(POS_W),
    .MOTOR_MAX_TORQUE(MOTOR_MAX_TORQUE)
) u_chk (.clk, .reset_n, .forwardLimitInput, .servoOnInput_n, .positionErrorClearInput,
    .directionSelectSetting, .limitEnableSetting, .stopMethodSetting, .plugBrakeTorqueLimit,
    .refPulse, .refFwd, .motorStopped, .shaftCcw, .motorStep, .overtravelStatus,
    .stopAction, .plugTorqueOut, .positionError);
`default_nettype wire

/* File: dosc_limit_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dosc_limit_model (
    input wire logic clk,
    input wire logic [1:0] trip,
    input wire logic bounce,
    output wire logic [1:0] lineOut
);
    for (genvar i = 0; i < 2; i++) begin : g_line
        logic [1:0] cnt_ff = 2'h0;
        logic last_ff = 1'b0;
        // A real contact chatters for a few cycles after it moves.
        always_ff @(posedge clk) begin
            last_ff <= trip[i];
            if (bounce && trip[i] != last_ff) begin
                cnt_ff <= 2'h3;
            end else if (cnt_ff != 2'h0) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
        assign lineOut[i] = (cnt_ff != 2'h0) ? cnt_ff[0] : trip[i];
    end
endmodule : dosc_limit_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [8:0] MAX_T = 9'h0C8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic fwdTrip = 1'b0;
    logic revTrip = 1'b0;
    logic bounce = 1'b0;
    wire logic [1:0] limLines;
    logic servoOn_n = 1'b0;
    logic clr = 1'b0;
    logic dir = 1'b0;
    logic [3:0] lim = 4'h0;
    logic [2:0] meth = 3'h0;
    logic [8:0] torque = 9'h12C;
    logic refPulse = 1'b0;
    logic refFwd = 1'b0;
    logic fbPulse = 1'b0;
    logic fbFwd = 1'b1;
    logic stopped = 1'b0;
    logic shaftCcw, motorStep, echoA, echoB, clamp;
    dosc_pkg::dosc_ot_t ot;
    dosc_pkg::dosc_act_t act;
    logic [8:0] torqueOut;
    logic signed [31:0] posErr;
    int errors = 0;
    int total_checks = 0;
    int seed = 92;
    int expErr, q, v;

    dosc_limit_model i_lim (.clk(clk), .trip({revTrip, fwdTrip}), .bounce(bounce),
        .lineOut(limLines));
    direction_overtravel_stop_control #(.DEBOUNCE_COUNT(4), .MOTOR_MAX_TORQUE(MAX_T)) i_dut (
        .clk(clk), .reset_n(reset_n), .forwardLimitInput(limLines[0]),
        .reverseLimitInput(limLines[1]), .servoOnInput_n(servoOn_n),
        .positionErrorClearInput(clr), .directionSelectSetting(dir), .limitEnableSetting(lim),
        .stopMethodSetting(meth), .plugBrakeTorqueLimit(torque), .refPulse(refPulse),
        .refFwd(refFwd), .fbPulse(fbPulse), .fbFwd(fbFwd), .motorStopped(stopped),
        .shaftCcw(shaftCcw), .motorStep(motorStep), .encoderEchoPhaseA(echoA),
        .encoderEchoPhaseB(echoB), .overtravelStatus(ot), .stopAction(act),
        .zeroClampActive(clamp), .plugTorqueOut(torqueOut), .positionError(posErr));

    // Free-running 50 MHz clock.
    initial begin
        forever #10 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Waits a bounded time for the stop action or the overtravel status to reach a value.
    task automatic waitV(input logic sel, input logic [4:0] want);
        int i;
        for (i = 0; i < 60 && (sel ? {1'b0, ot} : 5'(act)) !== want; i++) begin
            tick();
        end
        if (i == 60) begin
            errors++;
            conclude();
        end
    endtask : waitV

    task automatic rst(input logic d, input logic [3:0] l, input logic [2:0] m);
        dir = d;
        lim = l;
        meth = m;
        fwdTrip = 1'b0;
        revTrip = 1'b0;
        servoOn_n = 1'b0;
        reset_n = 1'b0;
        repeat (4) tick();
        chk(act, dosc_pkg::ACT_COAST); // power removed
        reset_n = 1'b1;
        expErr = 0;
        q = 0;
        waitV(1'b0, dosc_pkg::ACT_RUN);
    endtask : rst

    // The model tracks the position error and the echo quadrature phase as integers.
    task automatic step(input logic f, input logic acc);
        refPulse = 1'b1;
        refFwd = f;
        tick();
        refPulse = 1'b0;
        chk(motorStep, acc);
        if (acc) begin
            chk(shaftCcw, f ^ dir);
            expErr += f ? 1 : -1;
            q += f ? 1 : -1;
        end
        tick();
        chk(posErr, expErr);
        chk({echoA, echoB}, {q[1], q[1] ^ q[0]});
    endtask : step

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end

    initial begin
        for (int m = 0; m < 6; m++) begin
            rst(m[0], 4'h0, m[2:0]);
            meth = 3'((m + 1) % 6);
            repeat (3) begin
                v = $random(seed);
                step(v[0], 1'b1);
            end
            bounce = 1'b1;
            revTrip = 1'b1;
            waitV(1'b1, 5'h05);
            tick();
            chk(act, m == 0 ? dosc_pkg::ACT_DB : m == 1 ? dosc_pkg::ACT_COAST : dosc_pkg::ACT_PLUG);
            step(1'b0, 1'b0);
            stopped = 1'b1;
            tick();
            chk(act, m >= 4 ? dosc_pkg::ACT_CLAMP : dosc_pkg::ACT_COAST);
            chk(clamp, m >= 4);
            if (m >= 4) begin
                step(1'b1, 1'b1);
            end
            stopped = 1'b0;
            revTrip = 1'b0;
            waitV(1'b0, dosc_pkg::ACT_RUN);
            // host stops by servo-off only in this single check.
            servoOn_n = 1'b1;
            tick();
            chk(act, m[0] ? dosc_pkg::ACT_COAST : dosc_pkg::ACT_DB);
        end
        bounce = 1'b0;
        rst(1'b0, 4'h4, 3'h4);
        revTrip = 1'b1;
        repeat (12) tick();
        chk(ot, 4'h0);
        step(1'b0, 1'b1);
        fwdTrip = 1'b1;
        waitV(1'b1, 5'h0A);
        tick();
        chk(act, dosc_pkg::ACT_PLUG);
        step(1'b1, 1'b0);
        v = $random(seed);
        fbFwd = v[0];
        fbPulse = 1'b1;
        tick();
        fbPulse = 1'b0;
        expErr -= v[0] ? 1 : -1;
        tick();
        chk(posErr, expErr);
        clr = 1'b1;
        tick();
        clr = 1'b0;
        chk(posErr, 0);
        rst(1'b1, 4'h2, 3'h1);
        fwdTrip = 1'b1;
        repeat (12) tick();
        chk(ot, 4'h0);
        step(1'b1, 1'b1);
        for (int k = 0; k < 8; k++) begin
            v = (k < 2) ? k * 300 : {$random(seed)} % 301;
            torque = 9'(v);
            tick();
            tick();
            chk(torqueOut, v > MAX_T ? MAX_T : v);
        end
        conclude();
    end
endmodule : tb_top
`default_nettype wire
